// *** scop_ctrl_top.v ***
// chip control and output port registers behind a classic wishbone slave
// assumes a 32-bit wishbone master on clk and mode pins from outside the domain
`timescale 1ns/1ps
`include "scop_defs.vh"

module scop_ctrl_top #(
    parameter DIV_W = 24
) (
    input  wire        clk,
    input  wire        resetn,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire [1:0]  mode_pins,
    input  wire [7:0]  conv_result,
    output reg         chip_enable_ff,
    output reg         clock_source_select_ff,
    output reg         conv_start_ff,
    output reg  [7:0]  col_addr_ff,
    output reg  [8:0]  row_addr_ff,
    output wire        out_a_pin,
    output wire        out_b_pin
);

    // word index of a byte address
    function [5:0] word_index;
        input [7:0] adr;
        begin
            word_index = adr[7:2];
        end
    endfunction

    // mode pin synchroniser: three stages, a change counts when two and three agree
    reg [1:0] mode_s1_ff;
    reg [1:0] mode_s2_ff;
    reg [1:0] mode_s3_ff;
    reg [1:0] mode_ff;

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode_s1_ff <= 2'h0;
            mode_s2_ff <= 2'h0;
            mode_s3_ff <= 2'h0;
            mode_ff    <= 2'h0;
        end else begin
            mode_s1_ff <= mode_pins;
            mode_s2_ff <= mode_s1_ff;
            mode_s3_ff <= mode_s2_ff;
            if (mode_s2_ff == mode_s3_ff) begin
                mode_ff <= mode_s3_ff;
            end
        end
    end

    // register state
    reg        auto_advance_ff;
    reg        clk_sel_bit_ff;
    reg [2:0]  out_b_toggle_rate_ff;
    reg [2:0]  out_a_toggle_rate_ff;
    reg        out_b_level_ff;
    reg        out_a_level_ff;
    reg [2:0]  conv_count_ff;
    reg        conv_busy_ff;

    // bus decode
    wire       bus_req    = wb_cyc_i & wb_stb_i;
    wire [5:0] bus_idx    = word_index(wb_adr_i);
    wire       bus_fire   = bus_req & wb_ack_o;
    wire       write_fire = bus_fire & wb_we_i & wb_sel_i[0];
    wire       read_fire  = bus_fire & ~wb_we_i;
    wire       cc_write   = write_fire & (bus_idx == `SCOP_IDX_CHIP_CONTROL);
    wire       op_write   = write_fire & (bus_idx == `SCOP_IDX_OUTPUT_PORT);
    wire       result_read = read_fire & (bus_idx == `SCOP_IDX_CONV_RESULT);
    wire       usb_mode   = (mode_ff == `SCOP_MODE_USB);

    // assembled register images
    wire [7:0] chip_control_img = {
        mode_ff,                                // RULE1
        ~conv_busy_ff,                          // RULE3
        1'b0,                                   // RULE12
        1'b0,                                   // RULE12
        auto_advance_ff,
        clk_sel_bit_ff,
        chip_enable_ff
    };

    wire [7:0] output_port_img = {
        out_b_toggle_rate_ff,
        out_a_toggle_rate_ff,
        out_b_level_ff,
        out_a_level_ff
    };

    // read data mux
    reg [7:0] nxt_rd_byte;

    always @* begin
        nxt_rd_byte = 8'h00;
        case (bus_idx)
            `SCOP_IDX_CONV_RESULT:  nxt_rd_byte = conv_result;
            `SCOP_IDX_CHIP_CONTROL: nxt_rd_byte = chip_control_img;
            `SCOP_IDX_OUTPUT_PORT:  nxt_rd_byte = output_port_img;
            // unmapped indexes answer with zero
            default:                nxt_rd_byte = 8'h00;
        endcase
    end

    // ack one cycle after the request, dropped in the cycle after
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= bus_req & ~wb_ack_o;
            if (bus_req & ~wb_ack_o & ~wb_we_i) begin
                wb_dat_o <= {24'h000000, nxt_rd_byte};
            end else begin
                wb_dat_o <= 32'h00000000;
            end
        end
    end

    // chip_control writable bits; top five bits are never stored
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            auto_advance_ff <= 1'b0; // RULE2
            clk_sel_bit_ff  <= 1'b0; // RULE2
            chip_enable_ff  <= 1'b0; // RULE2
        end else if (cc_write) begin
            auto_advance_ff <= wb_dat_i[`SCOP_CC_AUTO_ADVANCE];
            clk_sel_bit_ff  <= wb_dat_i[`SCOP_CC_CLK_SEL];
            chip_enable_ff  <= wb_dat_i[`SCOP_CC_ENABLE]; // RULE7
        end
    end

    // clock source select only acts outside usb mode
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            clock_source_select_ff <= 1'b0;
        end else begin
            clock_source_select_ff <= clk_sel_bit_ff & ~usb_mode; // RULE6
        end
    end

    // output_port_control
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            out_b_toggle_rate_ff <= 3'h0;
            out_a_toggle_rate_ff <= 3'h0;
            out_b_level_ff       <= 1'b0;
            out_a_level_ff       <= 1'b0;
        end else if (op_write) begin
            out_b_toggle_rate_ff <= wb_dat_i[`SCOP_OP_B_RATE_HI:`SCOP_OP_B_RATE_LO]; // RULE8
            out_a_toggle_rate_ff <= wb_dat_i[`SCOP_OP_A_RATE_HI:`SCOP_OP_A_RATE_LO]; // RULE9
            out_b_level_ff       <= wb_dat_i[`SCOP_OP_B_LEVEL]; // RULE10
            out_a_level_ff       <= wb_dat_i[`SCOP_OP_A_LEVEL]; // RULE11
        end
    end

    // converter launch: only on a result read with auto-advance set and the chip enabled
    wire launch = result_read & auto_advance_ff & chip_enable_ff; // RULE4 RULE5 RULE7

    // conversion timer; disabling the chip shuts the converter down at once
    reg [2:0] nxt_conv_count;
    reg       nxt_conv_busy;

    always @* begin
        nxt_conv_count = conv_count_ff;
        nxt_conv_busy  = conv_busy_ff;
        if (!chip_enable_ff) begin
            nxt_conv_count = 3'h0; // RULE7
            nxt_conv_busy  = 1'b0;
        end else if (launch) begin
            nxt_conv_count = `SCOP_CONV_CYCLES; // RULE13
            nxt_conv_busy  = 1'b1;
        end else if (conv_busy_ff) begin
            nxt_conv_count = conv_count_ff - 3'h1;
            nxt_conv_busy  = (conv_count_ff != 3'h1);
        end
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            conv_count_ff <= 3'h0;
            conv_busy_ff  <= 1'b0; // RULE2
            conv_start_ff <= 1'b0;
        end else begin
            conv_count_ff <= nxt_conv_count;
            conv_busy_ff  <= nxt_conv_busy;
            conv_start_ff <= launch; // RULE13
        end
    end

    // address advance: column each launching read, row at the end of a column run
    reg [7:0] nxt_col;
    reg [8:0] nxt_row;

    always @* begin
        nxt_col = col_addr_ff;
        nxt_row = row_addr_ff;
        if (launch) begin
            if (col_addr_ff == `SCOP_COL_LAST) begin
                nxt_col = 8'h00; // RULE5
                if (row_addr_ff == `SCOP_ROW_LAST) begin
                    nxt_row = 9'h000;
                end else begin
                    nxt_row = row_addr_ff + 9'h001; // RULE5
                end
            end else begin
                nxt_col = col_addr_ff + 8'h01; // RULE5
            end
        end
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            col_addr_ff <= 8'h00;
            row_addr_ff <= 9'h000;
        end else begin
            col_addr_ff <= nxt_col;
            row_addr_ff <= nxt_row;
        end
    end

    // free-running divider; stops with the 12 MHz clock when the chip is disabled
    reg [DIV_W-1:0] div_count_ff;

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            div_count_ff <= {DIV_W{1'b0}};
        end else if (chip_enable_ff) begin
            div_count_ff <= div_count_ff + {{(DIV_W-1){1'b0}}, 1'b1}; // RULE14
        end
    end

    scop_pin_drive #(
        .DIV_W (DIV_W)
    ) u_out_a (
        .clk       (clk),
        .resetn    (resetn),
        .rate      (out_a_toggle_rate_ff),
        .level     (out_a_level_ff),
        .div_count (div_count_ff),
        .pin_ff    (out_a_pin)
    );

    scop_pin_drive #(
        .DIV_W (DIV_W)
    ) u_out_b (
        .clk       (clk),
        .resetn    (resetn),
        .rate      (out_b_toggle_rate_ff),
        .level     (out_b_level_ff),
        .div_count (div_count_ff),
        .pin_ff    (out_b_pin)
    );

endmodule // scop_ctrl_top

// *** scop_ctrl_top_assertions.sv ***
// port checks for the control and output port registers
// assumes bound to scop_ctrl_top; mirrors written registers itself
`timescale 1ns/1ps
module scop_chk #(
    parameter DIV_W = 24
) (
    input wire        clk,
    input wire        resetn,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [7:0]  wb_adr_i,
    input wire [3:0]  wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    input wire        clock_source_select_ff,
    input wire        chip_enable_ff,
    input wire        conv_start_ff,
    input wire [7:0]  col_addr_ff,
    input wire        out_a_pin
);
    reg  [7:0] cc_ff;
    reg  [7:0] op_ff;
    wire       wr_ok  = wb_ack_o && wb_we_i && wb_sel_i[0];
    wire       rd_res = wb_ack_o && !wb_we_i && wb_adr_i[7:2] == 6'h08;
    // a write lands at the edge that sees ack, as in the block
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cc_ff <= 8'h00;
            op_ff <= 8'h00;
        end else begin
            if (wr_ok && wb_adr_i[7:2] == 6'h09) cc_ff <= wb_dat_i[7:0];
            if (wr_ok && wb_adr_i[7:2] == 6'h0A) op_ff <= wb_dat_i[7:0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    a_ack_time: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    a_rdata_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("dat not 0");
    a_start_read: assert property (
        rd_res && cc_ff[2] && cc_ff[0] |-> ##[1:2] conv_start_ff) else $error("no start");
    a_no_start: assert property (rd_res && !cc_ff[2] |=> !conv_start_ff [*2])
        else $error("stray start");
    a_start_enable: assert property (conv_start_ff |-> chip_enable_ff)
        else $error("start while off");
    a_col_step: assert property (
        $changed(col_addr_ff) |-> col_addr_ff == $past(col_addr_ff) + 8'h01)
        else $error("bad column step");
    a_col_cause: assert property (
        $changed(col_addr_ff) |-> conv_start_ff || $past(conv_start_ff))
        else $error("column moved alone");
    a_clksel_off: assert property (
        !cc_ff[1] && !$past(cc_ff[1]) |-> !clock_source_select_ff)
        else $error("clock select set");
    a_pin_static: assert property (
        op_ff[4:2] == 3'h0 && $past(op_ff, 2) == op_ff |-> out_a_pin == op_ff[0])
        else $error("pin a level");
endmodule // scop_chk
bind scop_ctrl_top scop_chk #(.DIV_W(DIV_W)) chk (.clk(clk), .resetn(resetn),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .clock_source_select_ff(clock_source_select_ff), .chip_enable_ff(chip_enable_ff),
    .conv_start_ff(conv_start_ff), .col_addr_ff(col_addr_ff), .out_a_pin(out_a_pin));

// *** scop_ctrl_top_tb.sv ***
// self-checking bench for the control and output port registers
// assumes the host model and checker files are compiled first
`timescale 1ns/1ps
module scop_ctrl_top_tb;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic [1:0]  mode_pins = 2'h1;
    logic [7:0]  conv_result = 8'h5A;
    wire         cyc, stb, we, ack, ce, cs, st, pa, pb;
    wire  [7:0]  adr, col;
    wire  [3:0]  sel;
    wire  [8:0]  row;
    wire  [31:0] di, dq;
    logic [31:0] q;
    int          mismatches = 0;
    int          comparisons = 0;
    always #20 clk = ~clk;
    scop_host_model host (.clk(clk), .ack(ack), .rdat(dq), .cyc(cyc), .stb(stb), .we(we),
        .adr(adr), .sel(sel), .dat(di));
    scop_ctrl_top #(.DIV_W(6)) dut (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(di),
        .wb_dat_o(dq), .wb_ack_o(ack), .mode_pins(mode_pins), .conv_result(conv_result),
        .chip_enable_ff(ce), .clock_source_select_ff(cs), .conv_start_ff(st),
        .col_addr_ff(col), .row_addr_ff(row), .out_a_pin(pa), .out_b_pin(pb));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic t_reset;
        host.xfer(1'b0, 8'h24, 8'h00, q);
        chk(q, 32'h60);
        host.xfer(1'b0, 8'h28, 8'h00, q);
        chk(q, 32'h00);
        host.xfer(1'b0, 8'h3C, 8'h00, q);
        chk(q, 32'h00);
        // bit 3 set as well: it must neither stick nor act; bit 4 stays zero
        host.xfer(1'b1, 8'h24, 8'hE8, q);
        host.xfer(1'b0, 8'h24, 8'h00, q);
        chk(q, 32'h60);
    endtask
    task automatic t_auto;
        host.xfer(1'b1, 8'h24, 8'h01, q);
        host.xfer(1'b0, 8'h20, 8'h00, q);
        chk(q, 32'h5A);
        chk(32'(ce), 32'h1);
        chk(32'(col), 32'h0);
        host.xfer(1'b1, 8'h24, 8'h05, q);
        host.xfer(1'b0, 8'h20, 8'h00, q);
        host.xfer(1'b0, 8'h24, 8'h00, q);
        chk(q, 32'h45);
        repeat (6) @(posedge clk);
        host.xfer(1'b0, 8'h24, 8'h00, q);
        chk(q, 32'h65);
        chk(32'(col), 32'h1);
        // run off the end of the row to see the wrap and row step
        repeat (255) begin
            host.xfer(1'b0, 8'h20, 8'h00, q);
            repeat (7) @(posedge clk);
        end
        chk({col, 15'h0, row}, 32'h1);
        host.xfer(1'b1, 8'h24, 8'h04, q);
        host.xfer(1'b0, 8'h20, 8'h00, q);
        repeat (3) @(posedge clk);
        chk(32'(col), 32'h0);
        chk(32'(ce), 32'h0);
    endtask
    task automatic t_clk;
        mode_pins <= 2'h2;
        repeat (8) @(posedge clk);
        host.xfer(1'b1, 8'h24, 8'h03, q);
        repeat (3) @(posedge clk);
        chk(32'(cs), 32'h0);
        host.xfer(1'b0, 8'h24, 8'h00, q);
        chk(q, 32'hA3);
        mode_pins <= 2'h1;
        repeat (8) @(posedge clk);
        chk(32'(cs), 32'h1);
    endtask
    task automatic half(input int code, input logic b);
        logic v;
        int   n;
        // the first edge after a rate change may be a jump, so time the third one
        for (int k = 0; k < 3; k++) begin
            v = b ? pb : pa;
            n = 0;
            while ((b ? pb : pa) === v && n < 100) begin
                @(posedge clk);
                n++;
            end
        end
        chk(n, 2 ** (6 - code));
    endtask
    task automatic t_pins;
        host.xfer(1'b1, 8'h28, 8'h03, q);
        repeat (3) @(posedge clk);
        chk({pb, pa}, 32'h3);
        for (int c = 1; c < 5; c++) begin
            host.xfer(1'b1, 8'h28, {c[2:0], c[2:0], 2'b00}, q);
            half(c, 1'b0);
            half(c, 1'b1);
        end
        // reserved rate codes fall back to the level bits
        host.xfer(1'b1, 8'h28, 8'hBA, q);
        repeat (3) @(posedge clk);
        chk({pb, pa}, 32'h2);
    endtask
    task automatic conclude;
        if (mismatches == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        repeat (6) @(posedge clk);
        t_reset;
        t_auto;
        t_clk;
        t_pins;
        conclude;
    end
    // the whole run needs about 3000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        conclude;
    end
endmodule // scop_ctrl_top_tb

// *** scop_defs.vh ***
// constants for the sensor control and output port block
// assumes a 32-bit classic wishbone slave decoding word indexes
// What this block does
// RULE1: control bits 7:6 echo mode pins, unwritable
// RULE2: reset: idle bit one, low five zero
// RULE3: bit 5 reads converter idle, read-only
// RULE4: auto-advance off: result read changes nothing
// RULE5: auto-advance on: read advances column, row, converts
// RULE6: bit 1 picks clock source except usb
// RULE7: bit 0 clear halts clock and converter
// RULE8: bits 7:5 pick pin one level or rate
// RULE9: bits 4:2 pick pin zero level or rate
// RULE10: bit 1 drives pin one when static
// RULE11: bit 0 drives pin zero when static
// RULE12: bit 3 inert, bit 4 write zero
// RULE13: result read launches conversion, valid within six
// RULE14: square wave period equals divisor, half toggles
`ifndef SCOP_DEFS_VH
`define SCOP_DEFS_VH

// word indexes; the byte address is four times the index
`define SCOP_IDX_CONV_RESULT   6'h08
`define SCOP_IDX_CHIP_CONTROL  6'h09
`define SCOP_IDX_OUTPUT_PORT   6'h0A

// chip_control fields
`define SCOP_CC_MODE_HI        7
`define SCOP_CC_MODE_LO        6
`define SCOP_CC_IDLE           5
`define SCOP_CC_RSVD4          4
`define SCOP_CC_RSVD3          3
`define SCOP_CC_AUTO_ADVANCE   2
`define SCOP_CC_CLK_SEL        1
`define SCOP_CC_ENABLE         0
`define SCOP_CC_LOW_RESET      3'h0

// output_port_control fields
`define SCOP_OP_B_RATE_HI      7
`define SCOP_OP_B_RATE_LO      5
`define SCOP_OP_A_RATE_HI      4
`define SCOP_OP_A_RATE_LO      2
`define SCOP_OP_B_LEVEL        1
`define SCOP_OP_A_LEVEL        0
`define SCOP_OP_RESET          8'h00

// toggle rate codes
`define SCOP_RATE_STATIC       3'h0
`define SCOP_RATE_DIV_MAX      3'h4

// interface mode code that disables the clock source select
`define SCOP_MODE_USB          2'h2

// converter timing in clock cycles
`define SCOP_CONV_CYCLES       3'h6

// sensor array extent
`define SCOP_COL_LAST          8'hFF
`define SCOP_ROW_LAST          9'h12B

`endif

// *** scop_host_model.sv ***
// host model: classic wishbone master, one access at a time
// assumes the bench calls xfer and shares clk with the block
`timescale 1ns/1ps
module scop_host_model (
    input  wire         clk,
    input  wire         ack,
    input  wire  [31:0] rdat,
    output logic        cyc = 1'b0,
    output logic        stb = 1'b0,
    output logic        we  = 1'b0,
    output logic [7:0]  adr = 8'h00,
    output logic [3:0]  sel = 4'h1,
    output logic [31:0] dat = 32'h0
);
    // released lines show the inverse so stale values cannot pass
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [31:0] q);
        @(posedge clk);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, 24'h0, d};
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        {cyc, stb, we, adr, dat} <= {2'b00, ~w, ~a, ~dat};
    endtask
endmodule // scop_host_model

// *** scop_pin_drive.v ***
// one general-purpose output pin: static level or divided square wave
// assumes a free-running divider count from the parent, same clock
`timescale 1ns/1ps
`include "scop_defs.vh"

module scop_pin_drive #(
    parameter DIV_W = 24
) (
    input  wire             clk,
    input  wire             resetn,
    input  wire [2:0]       rate,
    input  wire             level,
    input  wire [DIV_W-1:0] div_count,
    output reg              pin_ff
);

    reg nxt_pin;

    // count bit k toggles every 2^k cycles, so code 1 (divisor 2^DIV_W) uses the top bit
    always @* begin
        nxt_pin = level;
        case (rate)
            `SCOP_RATE_STATIC: nxt_pin = level; // RULE10 RULE11
            3'h1:              nxt_pin = div_count[DIV_W-1]; // RULE14
            3'h2:              nxt_pin = div_count[DIV_W-2]; // RULE14
            3'h3:              nxt_pin = div_count[DIV_W-3]; // RULE14
            `SCOP_RATE_DIV_MAX: nxt_pin = div_count[DIV_W-4]; // RULE14
            // reserved codes fall back to the static level so the pin stays defined
            default:           nxt_pin = level;
        endcase
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_ff <= 1'b0;
        end else begin
            pin_ff <= nxt_pin;
        end
    end

endmodule // scop_pin_drive
